// >>> cbpe_params.svh
// constant definitions for the crossbar peripheral enable block
`ifndef CBPE_PARAMS_SVH
`define CBPE_PARAMS_SVH
`define CBPE_ADDR_EN0        8'hE1
`define CBPE_ADDR_EN1        8'hE2
`define CBPE_ADDR_EN2        8'hE3
`define CBPE_RST_EN0         8'h00
`define CBPE_RST_EN1         8'h00
`define CBPE_RST_EN2         8'h00
`define CBPE_EN1_WMASK       8'h7F
`define CBPE_EN2_GLOBAL_BIT  6
`define CBPE_NPINS           23
`define CBPE_UART_TX_PIN     4
`define CBPE_UART_RX_PIN     5
`define CBPE_SPIB_SCK_PIN    8
`define CBPE_SPIB_MISO_PIN   9
`define CBPE_SPIB_MOSI_PIN   10
`define CBPE_SPIB_NSS_PIN    11
`define CBPE_NFUNC           17
`define CBPE_PIN_IDX_W       5
`endif

// >>> cbpe_pkg.sv
// types for the crossbar peripheral enable block
package cbpe_pkg;
    // first enable register layout
    typedef struct packed {
        logic cmp1_async_out_en;
        logic cmp1_sync_out_en;
        logic cmp0_async_out_en;
        logic cmp0_sync_out_en;
        logic system_clock_pin_en;
        logic smbus_pin_en;
        logic spi_a_pin_en;
        logic uart_pin_en;
    } cbpe_en0_s;
    // second enable register layout
    typedef struct packed {
        logic       unused7;
        logic       spi_b_pin_en;
        logic       timer1_in_en;
        logic       timer0_in_en;
        logic       count_array_ext_in_en;
        logic [2:0] count_array_pin_sel;
    } cbpe_en1_s;
    // per-pin drive from the crossbar
    typedef struct packed {
        logic out;
        logic oe;
        logic open_drain;
    } cbpe_pin_s;
endpackage

// >>> cbpe_count_decode.sv
// counter-array module pin field decoder
`timescale 1ns/1ps
module cbpe_count_decode
(
    input  wire logic [2:0] sel_i,
    output logic      [5:0] module_en_o
);
    // =====================================
    // thermometer decode
    // 011 taken as three modules; 111 reserved and routes none
    always_comb
    begin
        case (sel_i)
            3'h0:    module_en_o = 6'h00;         // [R12]
            3'h1:    module_en_o = 6'h01;         // [R12]
            3'h2:    module_en_o = 6'h03;         // [R12]
            3'h3:    module_en_o = 6'h07;         // [R13]
            3'h4:    module_en_o = 6'h0F;         // [R12]
            3'h5:    module_en_o = 6'h1F;         // [R12]
            3'h6:    module_en_o = 6'h3F;         // [R12]
            default: module_en_o = 6'h00;         // [R13]
        endcase
    end
endmodule

// >>> cbpe_crossbar.sv
// crossbar peripheral enable registers and priority pin assignment
// Operation
// R1 - uart enable puts uart tx and rx on pins p0.4 and p0.5
// R2 - spi a enable routes clock, miso, mosi; slave select only in 4-wire
// R3 - smbus enable routes sda and scl to pins, else none
// R4 - system clock output enable drives system clock on an assigned pin
// R5 - comparator 0 sync and async outputs routed by bits 4 and 5
// R6 - comparator 1 sync and async outputs routed by bits 6 and 7
// R7 - spi b enable puts clock, miso, mosi on p1.0 to p1.2
// R8 - spi b slave select on p1.3 only when enabled and 4-wire
// R9 - bit 5 of second register connects timer 1 input from a pin
// R10 - bit 4 of second register connects timer 0 input from a pin
// R11 - bit 3 of second register connects counter array count input
// R12 - 3-bit field picks how many counter modules get pins, up to six
// R13 - software avoids code 111; code 011 decoded as three modules
// R14 - bit 7 of second register reads zero and ignores writes
// R15 - other functions take lowest free unskipped pin in priority order
// R16 - uart first, spi b next; spi a mode shifts lower functions
// R17 - all port drivers off while global crossbar enable is clear
// R18 - smbus pins forced open-drain when routed
// R19 - crossbar registers reset to zero
// R20 - new enables take effect the cycle after the write
`timescale 1ns/1ps
`include "cbpe_params.svh"
module cbpe_crossbar
(
    input  wire logic                              clock_i,
    input  wire logic                              rst_i,
    input  wire logic                              ce_i,
    input  wire logic [7:0]                        sfr_addr_i,
    input  wire logic                              sfr_wr_i,
    input  wire logic [7:0]                        sfr_wdata_i,
    output logic      [7:0]                        sfr_rdata_o,
    input  wire logic [`CBPE_NPINS-1:0]            pin_skip_mask_i,
    input  wire logic                              spi_a_four_wire_i,
    input  wire logic                              spi_b_four_wire_i,
    input  wire logic                              system_clock_i,
    input  wire logic                              uart_tx_i,
    input  wire logic                              spi_a_sck_i,
    input  wire logic                              spi_a_sck_oe_i,
    input  wire logic                              spi_a_miso_i,
    input  wire logic                              spi_a_miso_oe_i,
    input  wire logic                              spi_a_mosi_i,
    input  wire logic                              spi_a_mosi_oe_i,
    input  wire logic                              spi_b_sck_i,
    input  wire logic                              spi_b_sck_oe_i,
    input  wire logic                              spi_b_miso_i,
    input  wire logic                              spi_b_miso_oe_i,
    input  wire logic                              spi_b_mosi_i,
    input  wire logic                              spi_b_mosi_oe_i,
    input  wire logic                              smbus_sda_low_i,
    input  wire logic                              smbus_scl_low_i,
    input  wire logic                              cmp0_sync_i,
    input  wire logic                              cmp0_async_i,
    input  wire logic                              cmp1_sync_i,
    input  wire logic                              cmp1_async_i,
    input  wire logic [5:0]                        count_module_io_i,
    input  wire logic [5:0]                        count_module_io_oe_i,
    input  wire logic [`CBPE_NPINS-1:0]            pin_in_i,
    output logic      [`CBPE_NPINS-1:0]            pin_out_o,
    output logic      [`CBPE_NPINS-1:0]            pin_oe_o,
    output logic      [`CBPE_NPINS-1:0]            pin_open_drain_o,
    output logic                                   uart_rx_o,
    output logic                                   spi_a_sck_o,
    output logic                                   spi_a_miso_o,
    output logic                                   spi_a_mosi_o,
    output logic                                   spi_a_slave_select_o,
    output logic                                   spi_b_sck_o,
    output logic                                   spi_b_miso_o,
    output logic                                   spi_b_mosi_o,
    output logic                                   spi_b_slave_select_o,
    output logic                                   smbus_sda_o,
    output logic                                   smbus_scl_o,
    output logic                                   timer0_in_o,
    output logic                                   timer1_in_o,
    output logic                                   count_array_ext_in_o,
    output logic      [5:0]                        count_module_io_o,
    output logic      [`CBPE_NPINS-1:0]            pin_assigned_o
);
    import cbpe_pkg::*;

    localparam int NP = `CBPE_NPINS;
    localparam int NF = `CBPE_NFUNC;

    cbpe_en0_s en0_reg;
    cbpe_en1_s en1_reg;
    logic [7:0] en2_reg;
    logic [NP-1:0] sync1_reg;
    logic [NP-1:0] sync2_reg;
    logic [5:0] module_en;
    logic global_en;

    // =====================================
    // register file
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            en0_reg <= `CBPE_RST_EN0;                                     // [R19]
            en1_reg <= `CBPE_RST_EN1;                                     // [R19]
            en2_reg <= `CBPE_RST_EN2;
        end
        else if (ce_i && sfr_wr_i)
        begin
            // new value steers the walk from the next cycle on
            if (sfr_addr_i == `CBPE_ADDR_EN0)
                en0_reg <= sfr_wdata_i;                                   // [R20]
            if (sfr_addr_i == `CBPE_ADDR_EN1)
                en1_reg <= sfr_wdata_i & `CBPE_EN1_WMASK;                 // [R14]
            if (sfr_addr_i == `CBPE_ADDR_EN2)
                en2_reg <= sfr_wdata_i;
        end
    end

    // unmapped addresses read zero; unused low bits of the third register too
    always_comb
    begin
        case (sfr_addr_i)
            `CBPE_ADDR_EN0: sfr_rdata_o = en0_reg;
            `CBPE_ADDR_EN1: sfr_rdata_o = {1'b0, en1_reg[6:0]};           // [R14]
            `CBPE_ADDR_EN2: sfr_rdata_o = {en2_reg[7:6], 6'h00};
            default:        sfr_rdata_o = 8'h00;
        endcase
    end

    assign global_en = en2_reg[`CBPE_EN2_GLOBAL_BIT];

    cbpe_count_decode u_count_decode
    (
        .sel_i       (en1_reg.count_array_pin_sel),
        .module_en_o (module_en)
    );

    // =====================================
    // pad input synchroniser
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end
        else if (ce_i)
        begin
            sync1_reg <= pin_in_i;
            sync2_reg <= sync1_reg;
        end
    end

    // =====================================
    // priority function list, uart and spi b excluded (fixed)
    // order: spi a sck, miso, mosi, nss, smbus sda, scl, system_clock,
    // cmp0 sync, async, cmp1 sync, async, count modules 0..5, ext count,
    // timer0, timer1; combinational so a pin change follows the register
    logic [NF+2:0] fn_req;
    logic [NF+2:0] fn_out;
    logic [NF+2:0] fn_oe;
    logic [NF+2:0] fn_od;
    logic [4:0]    fn_pin [NF+3];
    logic [NF+2:0] fn_hit;
    logic [NP-1:0] fixed_taken;

    always_comb
    begin
        fn_req = {en1_reg.timer1_in_en,                                   // [R9]
                  en1_reg.timer0_in_en,                                   // [R10]
                  en1_reg.count_array_ext_in_en,                          // [R11]
                  module_en,                                              // [R12]
                  en0_reg.cmp1_async_out_en, en0_reg.cmp1_sync_out_en,    // [R6]
                  en0_reg.cmp0_async_out_en, en0_reg.cmp0_sync_out_en,    // [R5]
                  en0_reg.system_clock_pin_en,                                  // [R4]
                  {2{en0_reg.smbus_pin_en}},                              // [R3]
                  en0_reg.spi_a_pin_en & spi_a_four_wire_i,               // [R2]
                  {3{en0_reg.spi_a_pin_en}}};                             // [R2]
        fn_out = {3'h0, count_module_io_i, cmp1_async_i, cmp1_sync_i, cmp0_async_i,
                  cmp0_sync_i, system_clock_i, 2'h0, 1'b0, spi_a_mosi_i, spi_a_miso_i, spi_a_sck_i};
        fn_oe  = {3'h0, count_module_io_oe_i, 5'h1F, smbus_scl_low_i, smbus_sda_low_i,
                  1'b0, spi_a_mosi_oe_i, spi_a_miso_oe_i, spi_a_sck_oe_i};
        fn_od  = {{NF-3{1'b0}}, 2'h3, 4'h0};                              // [R18]
        fixed_taken = '0;
        fixed_taken[`CBPE_UART_TX_PIN]  = en0_reg.uart_pin_en;            // [R16]
        fixed_taken[`CBPE_UART_RX_PIN]  = en0_reg.uart_pin_en;
        fixed_taken[`CBPE_SPIB_SCK_PIN] = en1_reg.spi_b_pin_en;
        fixed_taken[`CBPE_SPIB_MISO_PIN] = en1_reg.spi_b_pin_en;
        fixed_taken[`CBPE_SPIB_MOSI_PIN] = en1_reg.spi_b_pin_en;
        fixed_taken[`CBPE_SPIB_NSS_PIN] = en1_reg.spi_b_pin_en & spi_b_four_wire_i; // [R8]
    end

    // walk: each requesting function takes the lowest free unskipped pin
    logic [NP-1:0] taken [NF+4];
    assign taken[0] = fixed_taken | pin_skip_mask_i;

    genvar f;
    generate
        for (f = 0; f < NF + 3; f++)
        begin : g_walk
            logic [NP-1:0] free_v;
            logic [NP-1:0] grant_v;
            assign free_v  = ~taken[f];
            assign grant_v = fn_req[f] ? (free_v & (~free_v + 1'b1)) : '0;   // [R15]
            assign taken[f+1] = taken[f] | grant_v;
            assign fn_hit[f]  = |grant_v;
            always_comb
            begin
                fn_pin[f] = 5'h00;
                for (int p = 0; p < NP; p++)
                    if (grant_v[p])
                        fn_pin[f] = p[4:0];
            end
        end
    endgenerate

    // =====================================
    // pad drive; inputs steered back from synchronised pads
    always_comb
    begin
        pin_out_o        = '0;
        pin_oe_o         = '0;
        pin_open_drain_o = '0;
        if (en0_reg.uart_pin_en)                                          // [R1]
        begin
            pin_out_o[`CBPE_UART_TX_PIN] = uart_tx_i;
            pin_oe_o[`CBPE_UART_TX_PIN]  = 1'b1;
        end
        if (en1_reg.spi_b_pin_en)                                         // [R7]
        begin
            pin_out_o[`CBPE_SPIB_SCK_PIN]  = spi_b_sck_i;
            pin_oe_o[`CBPE_SPIB_SCK_PIN]   = spi_b_sck_oe_i;
            pin_out_o[`CBPE_SPIB_MISO_PIN] = spi_b_miso_i;
            pin_oe_o[`CBPE_SPIB_MISO_PIN]  = spi_b_miso_oe_i;
            pin_out_o[`CBPE_SPIB_MOSI_PIN] = spi_b_mosi_i;
            pin_oe_o[`CBPE_SPIB_MOSI_PIN]  = spi_b_mosi_oe_i;
        end
        for (int i = 0; i < NF + 3; i++)
            if (fn_hit[i])
            begin
                pin_out_o[fn_pin[i]]        = fn_out[i];
                pin_oe_o[fn_pin[i]]         = fn_oe[i];
                pin_open_drain_o[fn_pin[i]] = fn_od[i];                   // [R18]
            end
        if (!global_en)
            pin_oe_o = '0;                                                // [R17]
        pin_assigned_o = taken[NF+3] & ~pin_skip_mask_i;
    end

    // disconnected inputs idle high, like an undriven pulled-up pad; timer 0, timer 1 and external count inputs idle low
    always_comb
    begin
        uart_rx_o            = en0_reg.uart_pin_en ? sync2_reg[`CBPE_UART_RX_PIN] : 1'b1;      // [R1]
        spi_b_sck_o          = en1_reg.spi_b_pin_en ? sync2_reg[`CBPE_SPIB_SCK_PIN] : 1'b1;    // [R7]
        spi_b_miso_o         = en1_reg.spi_b_pin_en ? sync2_reg[`CBPE_SPIB_MISO_PIN] : 1'b1;
        spi_b_mosi_o         = en1_reg.spi_b_pin_en ? sync2_reg[`CBPE_SPIB_MOSI_PIN] : 1'b1;
        spi_b_slave_select_o = fixed_taken[`CBPE_SPIB_NSS_PIN] ? sync2_reg[`CBPE_SPIB_NSS_PIN] : 1'b1; // [R8]
        spi_a_sck_o          = fn_hit[0] ? sync2_reg[fn_pin[0]] : 1'b1;   // [R2]
        spi_a_miso_o         = fn_hit[1] ? sync2_reg[fn_pin[1]] : 1'b1;
        spi_a_mosi_o         = fn_hit[2] ? sync2_reg[fn_pin[2]] : 1'b1;
        spi_a_slave_select_o = fn_hit[3] ? sync2_reg[fn_pin[3]] : 1'b1;
        smbus_sda_o          = fn_hit[4] ? sync2_reg[fn_pin[4]] : 1'b1;   // [R3]
        smbus_scl_o          = fn_hit[5] ? sync2_reg[fn_pin[5]] : 1'b1;
        for (int m = 0; m < 6; m++)
            count_module_io_o[m] = fn_hit[11+m] ? sync2_reg[fn_pin[11+m]] : 1'b1;
        count_array_ext_in_o = fn_hit[17] ? sync2_reg[fn_pin[17]] : 1'b0; // [R11]
        timer0_in_o          = fn_hit[18] ? sync2_reg[fn_pin[18]] : 1'b0; // [R10]
        timer1_in_o          = fn_hit[19] ? sync2_reg[fn_pin[19]] : 1'b0; // [R9]
    end
endmodule

// >>> cbpe_crossbar_assertions.sv
// concurrent checks on the crossbar peripheral enable ports
`timescale 1ns/1ps
`include "cbpe_params.svh"
module cbpe_crossbar_assertions
(
    input  wire logic                   clock_i,
    input  wire logic                   rst_i,
    input  wire logic                   ce_i,
    input  wire logic [7:0]             sfr_addr_i,
    input  wire logic                   sfr_wr_i,
    input  wire logic [7:0]             sfr_wdata_i,
    input  wire logic [7:0]             sfr_rdata_o,
    input  wire logic                   spi_b_four_wire_i,
    input  wire logic                   uart_tx_i,
    input  wire logic [`CBPE_NPINS-1:0] pin_in_i,
    input  wire logic [`CBPE_NPINS-1:0] pin_out_o,
    input  wire logic [`CBPE_NPINS-1:0] pin_oe_o,
    input  wire logic [`CBPE_NPINS-1:0] pin_open_drain_o,
    input  wire logic                   uart_rx_o,
    input  wire logic                   timer0_in_o,
    input  wire logic [`CBPE_NPINS-1:0] pin_assigned_o
);
    // ==========
    // shadow registers, so no check leans on the read path it judges
    logic [7:0] en0_reg;
    logic [7:0] en1_reg;
    logic [7:0] en2_reg;
    always_ff @(posedge clock_i)
    begin
        if (rst_i || (ce_i && sfr_wr_i && sfr_addr_i == `CBPE_ADDR_EN0))
            en0_reg <= rst_i ? 8'h00 : sfr_wdata_i;
        if (rst_i || (ce_i && sfr_wr_i && sfr_addr_i == `CBPE_ADDR_EN1))
            en1_reg <= rst_i ? 8'h00 : sfr_wdata_i;
        if (rst_i || (ce_i && sfr_wr_i && sfr_addr_i == `CBPE_ADDR_EN2))
            en2_reg <= rst_i ? 8'h00 : sfr_wdata_i;
    end
    // ==========
    // properties
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);
    property p_reset_clear;
        $past(rst_i) |-> sfr_rdata_o == 8'h00 && pin_oe_o == '0;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("state not clear after reset");
    property p_bit7_zero;
        sfr_addr_i == `CBPE_ADDR_EN1 |-> !sfr_rdata_o[7];
    endproperty
    a_bit7_zero: assert property (p_bit7_zero) else $error("unused bit reads one");
    property p_write_takes;
        ce_i && sfr_wr_i && sfr_addr_i == `CBPE_ADDR_EN0 ##1 sfr_addr_i == `CBPE_ADDR_EN0
            |-> sfr_rdata_o == $past(sfr_wdata_i);
    endproperty
    a_write_takes: assert property (p_write_takes) else $error("write not seen next cycle");
    property p_global_off;
        !en2_reg[6] |-> pin_oe_o == '0;
    endproperty
    a_global_off: assert property (p_global_off) else $error("pin driven while crossbar off");
    property p_uart_drive;
        en0_reg[0] && en2_reg[6] |-> pin_oe_o[4] && pin_out_o[4] == uart_tx_i;
    endproperty
    a_uart_drive: assert property (p_uart_drive) else $error("uart transmit not on pin 4");
    property p_uart_rx;
        (en0_reg[0]) [*3] |-> uart_rx_o == $past(pin_in_i[5], 2);
    endproperty
    a_uart_rx: assert property (p_uart_rx) else $error("uart receive not from pin 5");
    property p_smbus_od;
        pin_open_drain_o != '0 |-> en0_reg[2];
    endproperty
    a_smbus_od: assert property (p_smbus_od) else $error("open drain without smbus");
    property p_spib_fixed;
        en1_reg[6] |-> pin_assigned_o[10:8] == 3'b111;
    endproperty
    a_spib_fixed: assert property (p_spib_fixed) else $error("spi b pins not fixed");
    property p_spib_nss;
        en1_reg[6] && spi_b_four_wire_i |-> pin_assigned_o[11];
    endproperty
    a_spib_nss: assert property (p_spib_nss) else $error("spi b select pin missing");
    property p_timer0_idle;
        (!en1_reg[4]) [*3] |-> timer0_in_o == 1'b0;
    endproperty
    a_timer0_idle: assert property (p_timer0_idle) else $error("timer 0 input not idle");
endmodule
bind cbpe_crossbar cbpe_crossbar_assertions chk_u (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i),
    .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
    .spi_b_four_wire_i(spi_b_four_wire_i), .uart_tx_i(uart_tx_i), .pin_in_i(pin_in_i),
    .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .pin_open_drain_o(pin_open_drain_o),
    .uart_rx_o(uart_rx_o), .timer0_in_o(timer0_in_o), .pin_assigned_o(pin_assigned_o));

// >>> cbpe_periph_model.sv
// partner model of the on-chip peripherals and the port pads
`timescale 1ns/1ps
`include "cbpe_params.svh"
module cbpe_periph_model
(
    input  wire logic [`CBPE_NPINS-1:0] pin_out_i,
    input  wire logic [`CBPE_NPINS-1:0] pin_oe_i,
    input  wire logic                   clock_i,
    output logic      [31:0]            periph_o,
    output logic      [`CBPE_NPINS-1:0] pin_in_o
);
    // ==========
    // odd step keeps bit 0 toggling every cycle, so stale levels show up
    logic [31:0] step_reg = 32'h00000000;
    always_ff @(negedge clock_i)
    begin
        step_reg <= step_reg + 32'h9E3779B1;
    end
    assign periph_o = step_reg;
    // a released pad never keeps its last driven level
    assign pin_in_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & step_reg[`CBPE_NPINS+7:8]);
endmodule

// >>> tb_crossbar_peripheral_enable.sv
// self-checking testbench for the crossbar peripheral enable block
`timescale 1ns/1ps
`include "cbpe_params.svh"
module tb_crossbar_peripheral_enable;
    import cbpe_pkg::*;
    // ==========
    // signals
    logic        clock_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        ce_i = 1'b1;
    logic [7:0]  sfr_addr = 8'h00;
    logic        sfr_wr = 1'b0;
    logic [7:0]  sfr_wdata = 8'h00;
    logic [22:0] skip = 23'h0;
    logic        a_four = 1'b0;
    logic        b_four = 1'b0;
    logic [31:0] p;
    logic [22:0] pin_in, pin_out, pin_oe, pin_od, pin_asg;
    logic [7:0]  rdata;
    logic [22:0] d1, d2;
    wire  [19:0] ins;
    int          mismatches = 0;
    int          checks_done = 0;
    int          cycles = 0;
    initial
    begin
        forever #5 clock_i = ~clock_i;
    end
    // two-stage model of the pad synchroniser, frozen with the clock enable
    always @(posedge clock_i)
    begin
        if (ce_i)
        begin
            d1 <= pin_in;
            d2 <= d1;
        end
    end
    cbpe_periph_model model_u (.clock_i(clock_i), .pin_out_i(pin_out), .pin_oe_i(pin_oe), .periph_o(p),
        .pin_in_o(pin_in));
    cbpe_crossbar dut_u (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i), .sfr_addr_i(sfr_addr),
        .sfr_wr_i(sfr_wr), .sfr_wdata_i(sfr_wdata), .sfr_rdata_o(rdata), .pin_skip_mask_i(skip),
        .spi_a_four_wire_i(a_four), .spi_b_four_wire_i(b_four), .system_clock_i(p[0]), .uart_tx_i(p[1]),
        .spi_a_sck_i(p[2]), .spi_a_sck_oe_i(p[3]), .spi_a_miso_i(p[4]), .spi_a_miso_oe_i(p[5]),
        .spi_a_mosi_i(p[6]), .spi_a_mosi_oe_i(p[7]), .spi_b_sck_i(p[8]), .spi_b_sck_oe_i(p[9]),
        .spi_b_miso_i(p[10]), .spi_b_miso_oe_i(p[11]), .spi_b_mosi_i(p[12]), .spi_b_mosi_oe_i(p[13]),
        .smbus_sda_low_i(p[14]), .smbus_scl_low_i(p[15]), .cmp0_sync_i(p[16]), .cmp0_async_i(p[17]),
        .cmp1_sync_i(p[18]), .cmp1_async_i(p[19]), .count_module_io_i(p[25:20]),
        .count_module_io_oe_i(p[31:26]), .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
        .pin_open_drain_o(pin_od), .uart_rx_o(ins[0]), .spi_a_sck_o(ins[1]), .spi_a_miso_o(ins[2]),
        .spi_a_mosi_o(ins[3]), .spi_a_slave_select_o(ins[4]), .spi_b_sck_o(ins[5]), .spi_b_miso_o(ins[6]),
        .spi_b_mosi_o(ins[7]), .spi_b_slave_select_o(ins[8]), .smbus_sda_o(ins[9]), .smbus_scl_o(ins[10]),
        .count_module_io_o(ins[16:11]), .count_array_ext_in_o(ins[17]), .timer0_in_o(ins[18]),
        .timer1_in_o(ins[19]), .pin_assigned_o(pin_asg));
    // ==========
    // shared tasks
    task automatic chk(input string nm, input logic [22:0] exp, input logic [22:0] got);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_i);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clock_i);
        sfr_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        sfr_addr = a;
        #1;
        chk("sfr_rdata_o", {15'h0, exp}, {15'h0, rdata});
    endtask
    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ==========
    // scenarios
    task automatic t_regs;
        rd(`CBPE_ADDR_EN0, 8'h00);
        rd(`CBPE_ADDR_EN1, 8'h00);
        chk("pin_assigned_o", 23'h0, pin_asg);
        wr(`CBPE_ADDR_EN1, 8'hFF);
        rd(`CBPE_ADDR_EN1, 8'h7F);
        wr(`CBPE_ADDR_EN1, 8'h00);
        wr(8'hE4, 8'h55);
        ce_i = 1'b0;
        wr(`CBPE_ADDR_EN0, 8'h55);
        ce_i = 1'b1;
        rd(`CBPE_ADDR_EN0, 8'h00);
        $display("test regs done");
    endtask
    task automatic t_uart;
        wr(`CBPE_ADDR_EN0, 8'h01);
        chk("pin_assigned_o", 23'h30, pin_asg);
        chk("pin_oe_o", 23'h0, pin_oe);
        wr(`CBPE_ADDR_EN2, 8'h40);
        repeat (3) @(negedge clock_i);
        #1;
        chk("pin_out_o", {22'h0, p[1]}, {22'h0, pin_out[4]});
        chk("pin_oe_o", 23'h10, pin_oe);
        wr(`CBPE_ADDR_EN0, 8'h00);
        chk("pin_oe_o", 23'h0, pin_oe);
        $display("test uart done");
    endtask
    task automatic t_spib;
        wr(`CBPE_ADDR_EN1, 8'h40);
        chk("pin_assigned_o", 23'h700, pin_asg);
        b_four = 1'b1;
        #1;
        chk("pin_assigned_o", 23'hF00, pin_asg);
        b_four = 1'b0;
        wr(`CBPE_ADDR_EN1, 8'h00);
        $display("test spi b done");
    endtask
    task automatic t_walk;
        logic [22:0] sk [0:8] = '{23'h0, 23'h0, 23'h0, 23'h1, 23'h0, 23'h0, 23'h0, 23'h0, 23'h0};
        logic [7:0]  e1 [0:8] = '{8'h06, 8'h06, 8'h07, 8'h07, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};
        logic [22:0] as [0:8] = '{23'h1F, 23'h3F, 23'h7F, 23'hFE, 23'h1, 23'h1, 23'h1, 23'h1, 23'h1};
        logic [22:0] od [0:8] = '{23'h18, 23'h30, 23'h48, 23'hC0, 23'h0, 23'h0, 23'h0, 23'h0, 23'h0};
        for (int i = 0; i < 9; i++)
        begin
            skip = sk[i];
            a_four = (i == 1);
            wr(`CBPE_ADDR_EN0, e1[i]);
            chk("pin_assigned_o", as[i], pin_asg);
            chk("pin_open_drain_o", od[i], pin_od);
        end
        wr(`CBPE_ADDR_EN0, 8'h08);
        #1;
        chk("pin_out_o", {22'h0, p[0]}, {22'h0, pin_out[0]});
        wr(`CBPE_ADDR_EN0, 8'h00);
        chk("pin_assigned_o", 23'h0, pin_asg);
        skip = 23'h0;
        a_four = 1'b0;
        $display("test walk done");
    endtask
    task automatic t_count;
        logic [7:0] ins [0:2] = '{8'h20, 8'h10, 8'h08};
        for (int i = 0; i < 3; i++)
        begin
            wr(`CBPE_ADDR_EN1, ins[i]);
            chk("pin_assigned_o", 23'h1, pin_asg);
            chk("pin_oe_o", 23'h0, pin_oe);
        end
        for (int n = 0; n < 8; n++)
        begin
            wr(`CBPE_ADDR_EN1, 8'(n));
            chk("pin_assigned_o", (n == 7) ? 23'h0 : 23'((1 << n) - 1), pin_asg);
        end
        $display("test count done");
    endtask
    task automatic t_inputs;
        wr(`CBPE_ADDR_EN1, 8'h38);
        chk("inputs", {3'h0, d2[2:0], 17'h1FFFF}, {3'h0, ins});
        a_four = 1'b1;
        b_four = 1'b1;
        wr(`CBPE_ADDR_EN0, 8'h07);
        wr(`CBPE_ADDR_EN1, 8'h41);
        chk("inputs", {6'h00, 5'h1F, d2[12], d2[7:6], d2[11:8], d2[3:0], d2[5]}, {3'h0, ins});
        wr(`CBPE_ADDR_EN0, 8'h00);
        wr(`CBPE_ADDR_EN1, 8'h00);
        chk("inputs", {6'h00, 17'h1FFFF}, {3'h0, ins});
        a_four = 1'b0;
        b_four = 1'b0;
        $display("test inputs done");
    endtask
    // ==========
    // main sequence and hang guard
    always @(posedge clock_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            print_verdict();
        end
    end
    initial
    begin
        repeat (8) @(negedge clock_i);
        rst_i = 1'b0;
        t_regs();
        t_uart();
        t_spib();
        t_walk();
        t_count();
        t_inputs();
        print_verdict();
    end
endmodule
